// *** pc_stack_pkg.sv ***
// constants and types for the instruction sequencing block
// Function
// RULE1 - 12-bit counter holds next instruction address
// RULE2 - ordinary instruction advances pointer by length
// RULE3 - five jumps load operand destination
// RULE4 - call saves pointer, then loads destination
// RULE5 - return restores saved address
// RULE6 - reset sets pointer to zero
// RULE7 - 1-bit depth: call increments, return decrements
// RULE8 - reset clears depth pointer
// RULE9 - overflow or underflow forces system reset
// RULE10 - depth pointer changes only by call/return/reset
// RULE11 - 12-bit save register, low byte shared, kept
// RULE12 - fault reset also clears depth pointer
package pc_stack_pkg;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned LEN_W       = 2;
  localparam int unsigned CELL_W      = 8;
  localparam logic [11:0] PC_RESET    = 12'h000;
  localparam logic        DEPTH_RESET = 1'b0;
  localparam logic        DEPTH_MAX   = 1'b1;

  typedef enum logic [3:0] {
    op_step,
    op_jump_always,
    op_jump_on_carry,
    op_jump_on_no_carry,
    op_jump_on_status_flag,
    op_jump_on_no_status_flag,
    op_call,
    op_return
  } seq_op_t;
endpackage

// *** return_address_save.sv ***
// return address save register with shared low byte data cell
module return_address_save
  import pc_stack_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned CW = CELL_W
) (
  input  wire logic          clk,
  input  wire logic          save,
  input  wire logic [AW-1:0] save_addr,
  input  wire logic          cell_we,
  input  wire logic [CW-1:0] cell_wdata,
  output logic      [AW-1:0] value
);
  logic [AW-1:0] ras_q;
  logic [AW-1:0] ras_d;

  // not reset: keeps old data across reset and after a return
  assign ras_d = save ? save_addr :                                   // RULE4
                 cell_we ? {ras_q[AW-1:CW], cell_wdata} : ras_q;       // RULE11
  always_ff @(posedge clk) begin
    ras_q <= ras_d;
  end
  assign value = ras_q;
endmodule

// *** program_counter_call_stack.sv ***
// program counter and one-level call stack
module program_counter_call_stack
  import pc_stack_pkg::*;
#(
  parameter int unsigned AW = ADDR_W,
  parameter int unsigned CW = CELL_W
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          exec,
  input  wire seq_op_t       op,
  input  wire logic [LEN_W-1:0] instr_len,
  input  wire logic [AW-1:0] operand_addr,
  input  wire logic          carry,
  input  wire logic          status_flag,
  input  wire logic          cell_we,
  input  wire logic [CW-1:0] cell_wdata,
  output logic      [AW-1:0] next_instruction_pointer,
  output logic               call_depth_pointer,
  output logic      [AW-1:0] return_address_save_q,
  output logic      [CW-1:0] page0_last_cell,
  output logic               hang_reset
);
  logic          rst_s1_q;
  logic          rst_s2_q;
  logic [AW-1:0] pc_q;
  logic [AW-1:0] pc_d;
  logic          depth_q;
  logic          depth_d;
  logic          hang_q;
  logic [AW-1:0] ras_value;
  logic [AW-1:0] ras_out_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire is_call  = exec && (op == op_call);
  wire is_ret   = exec && (op == op_return);
  wire take_jmp = exec && ((op == op_jump_always) ||
                           (op == op_jump_on_carry && carry) ||
                           (op == op_jump_on_no_carry && !carry) ||
                           (op == op_jump_on_status_flag && status_flag) ||
                           (op == op_jump_on_no_status_flag && !status_flag));
  wire overflow  = is_call && (depth_q == DEPTH_MAX);                  // RULE9
  wire underflow = is_ret && (depth_q == DEPTH_RESET);                 // RULE9
  wire fault     = overflow || underflow;
  wire save      = is_call && !overflow;                               // RULE4
  wire [AW-1:0] pc_step = pc_q + AW'(instr_len);                       // RULE2

  assign pc_d = fault    ? PC_RESET :                                  // RULE9
                is_call  ? operand_addr :                              // RULE4
                is_ret   ? ras_value :                                 // RULE5
                take_jmp ? operand_addr :                              // RULE3
                exec     ? pc_step : pc_q;                             // RULE1
  // only call, return and reset move the depth; no direct write path
  assign depth_d = fault  ? DEPTH_RESET :                              // RULE12
                   is_call ? 1'b1 :                                    // RULE7
                   is_ret  ? 1'b0 : depth_q;                           // RULE10

  return_address_save #(.AW(AW), .CW(CW)) u_ras (
    .clk        (clk),
    .save       (save),
    .save_addr  (pc_step),
    .cell_we    (cell_we && !save),
    .cell_wdata (cell_wdata),
    .value      (ras_value)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc_q    <= PC_RESET;                                             // RULE6
      depth_q <= DEPTH_RESET;                                          // RULE8
      hang_q  <= 1'b0;
    end else if (!rst_s2_q) begin
      pc_q    <= PC_RESET;                                             // RULE6
      depth_q <= DEPTH_RESET;                                          // RULE8
      hang_q  <= 1'b0;
    end else begin
      pc_q    <= pc_d;
      depth_q <= depth_d;
      hang_q  <= fault;                                                // RULE9
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ras_out_q <= '0;
    end else begin
      ras_out_q <= ras_value;
    end
  end

  assign next_instruction_pointer = pc_q;
  assign call_depth_pointer       = depth_q;
  assign hang_reset               = hang_q;
  assign return_address_save_q    = ras_out_q;
  assign page0_last_cell          = ras_out_q[CW-1:0];
endmodule

// *** pcs_checker.sv ***
// assertions on the program counter and call stack ports
module pcs_checker
  import pc_stack_pkg::*;
#(parameter int unsigned AW = ADDR_W, parameter int unsigned CW = CELL_W) (
  input wire logic          clk, rstn, exec, carry, status_flag, cell_we,
  input wire seq_op_t       op,
  input wire logic [LEN_W-1:0] instr_len,
  input wire logic [AW-1:0] operand_addr, next_instruction_pointer, return_address_save_q,
  input wire logic [CW-1:0] cell_wdata, page0_last_cell,
  input wire logic          call_depth_pointer, hang_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [AW-1:0] nip = next_instruction_pointer;
  wire          dep = call_depth_pointer;
  wire          cl  = exec && op == op_call;
  wire          rt  = exec && op == op_return;
  property p_step; exec && op == op_step |=> nip == $past(nip + AW'(instr_len)); endproperty
  a_step: assert property (p_step) else $error("step address");
  property p_jmp; exec && op == op_jump_always |=> nip == $past(operand_addr); endproperty
  a_jmp: assert property (p_jmp) else $error("jump address");
  property p_jnc;
    exec && op == op_jump_on_no_carry && !carry |=> nip == $past(operand_addr);
  endproperty
  a_jnc: assert property (p_jnc) else $error("jump no carry");
  property p_jf;
    exec && op == op_jump_on_status_flag && status_flag |=> nip == $past(operand_addr);
  endproperty
  a_jf: assert property (p_jf) else $error("jump on status flag");
  property p_call;
    cl && !dep |=> nip == $past(operand_addr) && dep
      ##1 return_address_save_q == $past(nip + AW'(instr_len), 2);
  endproperty
  a_call: assert property (p_call) else $error("call");
  property p_ret;
    rt && dep && !$past(cl) |=> !dep && nip == ($past(cell_we, 2) ?
      {$past(return_address_save_q[AW-1:CW]), $past(cell_wdata, 2)} :
      $past(return_address_save_q));
  endproperty
  a_ret: assert property (p_ret) else $error("return");
  property p_hang; cl && dep || rt && !dep |=> hang_reset && nip == '0 && !dep; endproperty
  a_hang: assert property (p_hang) else $error("stack fault");
  property p_dep; !$stable(dep) |-> $past(cl || rt); endproperty
  a_dep: assert property (p_dep) else $error("depth change");
  property p_cell; cell_we && !(cl && !dep) |-> ##2 page0_last_cell == $past(cell_wdata, 2);
  endproperty
  a_cell: assert property (p_cell) else $error("shared cell");
  c_call: cover property (cl && !dep);
  c_ret: cover property (rt && dep);
  c_hang: cover property (hang_reset);
endmodule

bind program_counter_call_stack pcs_checker #(.AW(AW), .CW(CW)) i_chk (.*);

// *** program_counter_call_stack_tb.sv ***
// self-checking bench for the program counter and call stack
module program_counter_call_stack_tb;
  import pc_stack_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, exec = 0, carry = 0, status_flag = 0, cell_we = 0, v = 0;
  seq_op_t     op = op_step;
  logic [1:0]  instr_len = 2'h1;
  logic [11:0] operand_addr = 12'h0, next_instruction_pointer, return_address_save_q;
  logic [11:0] m_pc = 12'h0, m_s;
  logic [7:0]  cell_wdata = 8'h0, page0_last_cell;
  logic        call_depth_pointer, hang_reset, m_d = 0;
  logic [13:0] q[$];
  int          error_cnt = 0, n_checks = 0;
  program_counter_call_stack i_dut (.*);
  always #4 clk = ~clk;
  task automatic chk(logic [13:0] e, s);
    n_checks++;
    if (e !== s) begin
      error_cnt++;
      $display("wrong value pc_depth_hang exp %h got %h", e, s);
    end
  endtask
  task automatic ex(seq_op_t o, logic c);
    logic t, f;
    @(negedge clk);
    {exec, op, carry, status_flag} = {1'b1, o, c, c};
    {instr_len, operand_addr} = {2'($urandom_range(3, 1)), 12'($urandom)};
    {cell_we, cell_wdata} = 9'($urandom);
    t = o == op_jump_always || (o == op_jump_on_carry || o == op_jump_on_status_flag) && c
      || (o == op_jump_on_no_carry || o == op_jump_on_no_status_flag) && !c;
    f = o == op_call && m_d || o == op_return && !m_d;
    if (f) {m_pc, m_d} = 13'h0;
    else if (o == op_call) {m_s, m_pc, m_d} = {m_pc + 12'(instr_len), operand_addr, 1'b1};
    else if (o == op_return) {m_pc, m_d} = {m_s, 1'b0};
    else m_pc = t ? operand_addr : m_pc + 12'(instr_len);
    if (cell_we && !(o == op_call && !f)) m_s[7:0] = cell_wdata;
    q.push_back({m_pc, m_d, f});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) v <= exec;
  always @(negedge clk) if (v) chk(q.pop_front(), {next_instruction_pointer,
    call_depth_pointer, hang_reset});
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  initial begin
    void'($urandom(32'h0b28355f));
    repeat (5) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    chk(14'h0, {next_instruction_pointer, call_depth_pointer, hang_reset});
    for (int i = 0; i < 32; i++) ex(seq_op_t'(i % 8), i[3]);
    ex(op_call, 0);
    ex(op_call, 0);
    ex(op_return, 0);
    @(negedge clk) exec = 0;
    $display("test table done");
    for (int i = 0; i < 400; i++) ex(seq_op_t'($urandom_range(7)), 1'($urandom));
    @(negedge clk) exec = 0;
    $display("test random done");
    repeat (3) @(negedge clk);
    summarize();
  end
endmodule
